// File: padm_defines.svh
// Constants of the twelve-channel phase-angle dimmer: offsets, fields, timing.
// Assumes a 250 MHz system clock and a word-aligned AHB-Lite register map.
`ifndef PADM_DEFINES_SVH
`define PADM_DEFINES_SVH

`define PADM_NUM_CH        12
`define PADM_FIRST_OUT     5
`define PADM_LAST_OUT      16

`define PADM_CLK_NS        4
`define PADM_TICK_NS       53000
`define PADM_TICK_CYC      (`PADM_TICK_NS / `PADM_CLK_NS)
`define PADM_PULSE_NS      10000
`define PADM_PULSE_CYC     (`PADM_PULSE_NS / `PADM_CLK_NS)

`define PADM_MAX_50HZ      8'hBC
`define PADM_MAX_60HZ      8'h9C
`define PADM_MIN_DELAY     8'h01

`define PADM_OFS_CTRL      8'h00
`define PADM_OFS_MODE      8'h04
`define PADM_OFS_STATUS    8'h08
`define PADM_OFS_ERR       8'h0C
`define PADM_OFS_FIRED     8'h10
`define PADM_OFS_DELAY0    8'h40
`define PADM_OFS_DELAY11   8'h6C

`define PADM_CTRL_ZC_EN    0
`define PADM_CTRL_HZ60     1
`define PADM_CTRL_RESET    32'h0000_0000
`define PADM_MODE_RESET    24'h00_0000
`define PADM_DELAY_RESET   8'h00

`endif

// File: padm_pkg.sv
// Types shared by the dimmer modules.
// Assumes padm_defines.svh for the figures.
`include "padm_defines.svh"
package padm_pkg;
  typedef enum logic [1:0] {
    PADM_MODE_OFF,
    PADM_MODE_DIM,
    PADM_MODE_ON,
    PADM_MODE_OFF2
  } padm_mode_type;

  typedef enum logic [1:0] {
    PADM_BUS_IDLE,
    PADM_BUS_WAIT,
    PADM_BUS_DONE
  } padm_bus_state_type;

  typedef logic [7:0] padm_delay_type;
endpackage

// File: padm_reg_if.sv
// Register access path between the bus slave and the dimmer core.
// Assumes one write strobe per bus write and a combinational read value.
`timescale 1ns/10ps
interface padm_reg_if;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport slave (output wr, output addr, output wdata, input rdata);
  modport regs  (input wr, input addr, input wdata, output rdata);
endinterface

// File: padm_ahb_slave.sv
// AHB-Lite slave: one wait state per transfer, response always OKAY.
// Assumes single-word transfers and that hready_i is this slave's own hreadyout.
`timescale 1ns/10ps
module padm_ahb_slave
  import padm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // AHB-Lite
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Register side
  padm_reg_if.slave        reg_if
);
  padm_bus_state_type state_q;
  logic               write_q;
  logic [7:0]         addr_q;
  logic               accept;

  assign accept       = hsel_i & hready_i & htrans_i[1];
  assign reg_if.addr  = addr_q;
  assign reg_if.wdata = hwdata_i;
  assign reg_if.wr    = (state_q == PADM_BUS_WAIT) & write_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q     <= PADM_BUS_IDLE;
      write_q     <= 1'b0;
      addr_q      <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
      case (state_q)
        PADM_BUS_WAIT: begin
          // Wait state gives the read value a register stage
          hrdata_o    <= write_q ? 32'h0000_0000 : reg_if.rdata;
          hreadyout_o <= 1'b1;
          state_q     <= PADM_BUS_DONE;
        end
        default: begin
          if (accept) begin
            // Upper address bits ignored; map mirrors every 256 bytes
            addr_q      <= {haddr_i[7:2], 2'b00};
            write_q     <= hwrite_i;
            hreadyout_o <= 1'b0;
            state_q     <= PADM_BUS_WAIT;
          end else begin
            state_q <= PADM_BUS_IDLE;
          end
        end
      endcase
    end
  end
endmodule // padm_ahb_slave

// File: padm_timebase.sv
// Zero-cross edge detector and tick generator for the dimmer slots.
// Assumes zero_cross_i already synchronous to clk_i.
`timescale 1ns/10ps
`include "padm_defines.svh"
module padm_timebase #(
  parameter int TICK_CYC = `PADM_TICK_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Control
  input  wire logic zero_cross_i,
  input  wire logic zc_enable_i,
  // Events
  output logic      half_start_o,
  output logic      tick_o
);
  logic        zc_prev_q;
  logic [15:0] tick_cnt_q;
  logic        zc_fall;

  assign zc_fall = zc_prev_q & ~zero_cross_i & zc_enable_i;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      zc_prev_q    <= 1'b1;
      half_start_o <= 1'b0;
    end else begin
      zc_prev_q    <= zero_cross_i;
      half_start_o <= zc_fall;
    end
  end

  // Tick phase restarts at each crossing so slot 1 is a full tick late
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_q <= 16'h0000;
      tick_o     <= 1'b0;
    end else if (zc_fall) begin
      tick_cnt_q <= 16'h0000;
      tick_o     <= 1'b0;
    end else if (tick_cnt_q == 16'(TICK_CYC - 1)) begin
      tick_cnt_q <= 16'h0000;
      tick_o     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_o     <= 1'b0;
    end
  end
endmodule // padm_timebase

// File: padm_dimmer.sv
// Twelve-channel phase-angle dimmer core with AHB-Lite register access.
// Assumes an opto-isolated zero-cross signal and non-zero-crossing relays on the outputs.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
`include "padm_defines.svh"
module padm_dimmer
  import padm_pkg::*;
#(
  parameter int TICK_CYC = `PADM_TICK_CYC
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  // AHB-Lite
  input  wire logic                        hsel_i,
  input  wire logic [31:0]                 haddr_i,
  input  wire logic [1:0]                  htrans_i,
  input  wire logic [2:0]                  hsize_i,
  input  wire logic                        hwrite_i,
  input  wire logic [31:0]                 hwdata_i,
  input  wire logic                        hready_i,
  output logic [31:0]                      hrdata_o,
  output logic                             hreadyout_o,
  output logic                             hresp_o,
  // Mains and relays
  input  wire logic                        zero_cross_i,
  output logic [`PADM_LAST_OUT:`PADM_FIRST_OUT] dimmer_out_o
);
  localparam int NCH = `PADM_NUM_CH;

  padm_reg_if reg_if ();

  logic [31:0]    ctrl_q;
  logic [23:0]    mode_q;
  padm_delay_type delay_q   [NCH];
  padm_delay_type shadow_q  [NCH];
  logic [11:0]    pulse_q   [NCH];
  logic [NCH-1:0] fired_q;
  logic [NCH-1:0] err_q;
  logic [7:0]     slot_q;
  logic [15:0]    half_cnt_q;
  logic           half_start;
  logic           tick;
  logic [NCH-1:0] bad_wr;
  logic [NCH-1:0] fire_now;
  logic [31:0]    rdata;

  // Channel index of a delay register, or all ones when not one
  function automatic logic [3:0] chan_of(input logic [7:0] addr);
    logic [7:0] idx;
    idx = (addr - `PADM_OFS_DELAY0) >> 2;
    if (addr >= `PADM_OFS_DELAY0 && addr <= `PADM_OFS_DELAY11) begin
      chan_of = idx[3:0];
    end else begin
      chan_of = 4'hF;
    end
  endfunction

  // Highest legal delay for the configured mains frequency
  function automatic padm_delay_type max_delay(input logic hz60);
    max_delay = hz60 ? `PADM_MAX_60HZ : `PADM_MAX_50HZ;
  endfunction

  padm_ahb_slave u_slave (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hready_i),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .reg_if      (reg_if)
  );

  padm_timebase #(
    .TICK_CYC (TICK_CYC)
  ) u_timebase (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .zero_cross_i (zero_cross_i),
    .zc_enable_i  (ctrl_q[`PADM_CTRL_ZC_EN]),
    .half_start_o (half_start),
    .tick_o       (tick)
  );

  // Control and mode registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= `PADM_CTRL_RESET;
      mode_q <= `PADM_MODE_RESET;
    end else if (reg_if.wr) begin
      if (reg_if.addr == `PADM_OFS_CTRL) begin
        ctrl_q <= {30'h0000_0000, reg_if.wdata[1:0]};
      end
      if (reg_if.addr == `PADM_OFS_MODE) begin
        mode_q <= reg_if.wdata[23:0];
      end
    end
  end

  // Delay writes outside the legal range are dropped and flagged
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      bad_wr[i] = reg_if.wr && chan_of(reg_if.addr) == 4'(i) &&
                  (reg_if.wdata[31:0] < 32'(`PADM_MIN_DELAY) ||
                   reg_if.wdata[31:0] > 32'(max_delay(ctrl_q[`PADM_CTRL_HZ60])));
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < NCH; i++) begin
        delay_q[i] <= `PADM_DELAY_RESET;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (reg_if.wr && chan_of(reg_if.addr) == 4'(i) && !bad_wr[i]) begin
          delay_q[i] <= reg_if.wdata[7:0];
        end
      end
    end
  end

  // Sticky error flags, write one to clear; a new error wins over the clear
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      err_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (bad_wr[i]) begin
          err_q[i] <= 1'b1;
        end else if (reg_if.wr && reg_if.addr == `PADM_OFS_ERR && reg_if.wdata[i]) begin
          err_q[i] <= 1'b0;
        end
      end
    end
  end

  // Delays latched at the crossing so a rewrite never splits a half cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < NCH; i++) begin
        shadow_q[i] <= `PADM_DELAY_RESET;
      end
    end else if (half_start) begin
      for (int i = 0; i < NCH; i++) begin
        shadow_q[i] <= delay_q[i];
      end
    end
  end

  // Slot counter in ticks since the last crossing
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      slot_q     <= 8'h00;
      half_cnt_q <= 16'h0000;
    end else if (half_start) begin
      slot_q     <= 8'h00;
      half_cnt_q <= half_cnt_q + 16'h0001;
    end else if (tick && slot_q != 8'hFF) begin
      slot_q <= slot_q + 8'h01;
    end
  end

  // A channel fires once, on the tick that reaches its delay
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      fire_now[i] = tick && !half_start && !fired_q[i] && shadow_q[i] != 8'h00 &&
                    slot_q + 8'h01 == shadow_q[i];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fired_q <= '0;
    end else if (half_start) begin
      fired_q <= '0;
    end else begin
      fired_q <= fired_q | fire_now;
    end
  end

  // Short gate pulse; the relay latches on until the next crossing
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < NCH; i++) begin
        pulse_q[i] <= 12'h000;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (fire_now[i]) begin
          pulse_q[i] <= 12'(`PADM_PULSE_CYC);
        end else if (pulse_q[i] != 12'h000) begin
          pulse_q[i] <= pulse_q[i] - 12'h001;
        end
      end
    end
  end

  // Output n+4 carries channel n
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dimmer_out_o <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        case (padm_mode_type'(mode_q[2*i +: 2]))
          PADM_MODE_ON:  dimmer_out_o[i + `PADM_FIRST_OUT] <= 1'b1;
          PADM_MODE_DIM: dimmer_out_o[i + `PADM_FIRST_OUT] <= pulse_q[i] != 12'h000;
          default:       dimmer_out_o[i + `PADM_FIRST_OUT] <= 1'b0;
        endcase
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (reg_if.addr)
      `PADM_OFS_CTRL:   rdata = ctrl_q;
      `PADM_OFS_MODE:   rdata = {8'h00, mode_q};
      `PADM_OFS_STATUS: rdata = {8'h00, slot_q, half_cnt_q};
      `PADM_OFS_ERR:    rdata = {20'h0_0000, err_q};
      `PADM_OFS_FIRED:  rdata = {20'h0_0000, fired_q};
      default: begin
        if (chan_of(reg_if.addr) != 4'hF) begin
          rdata = {24'h00_0000, delay_q[chan_of(reg_if.addr)]};
        end
      end
    endcase
  end
  assign reg_if.rdata = rdata;
endmodule // padm_dimmer

// File: padm_dimmer_assertions.sv
// Port checker for the dimmer top; shadows control, mode and two delays.
// Assumes hready_i is tied to hreadyout_o and one wait state per transfer.
`timescale 1ns/10ps
`include "padm_defines.svh"
module padm_dimmer_assertions #(
  parameter int TICK_CYC = `PADM_TICK_CYC
) (
  // Clock and reset
  input wire logic                               clk_i,
  input wire logic                               reset_i,
  // Bus
  input wire logic                               hsel_i,
  input wire logic [31:0]                        haddr_i,
  input wire logic [1:0]                         htrans_i,
  input wire logic                               hwrite_i,
  input wire logic [31:0]                        hwdata_i,
  input wire logic                               hready_i,
  input wire logic                               hreadyout_o,
  // Mains and relays
  input wire logic                               zero_cross_i,
  input wire logic [`PADM_LAST_OUT:`PADM_FIRST_OUT] dimmer_out_o
);
  localparam int PULSE_CYC = `PADM_PULSE_CYC;
  logic        pend_q;
  logic [7:0]  adr_q;
  logic [1:0]  ctl_q;
  logic [23:0] mode_q;
  logic [7:0]  d1_q;
  logic [7:0]  d12_q;
  logic [7:0]  s1_q;
  logic [7:0]  s12_q;
  logic        zc_q;
  logic        seen_q;
  logic [31:0] sc_q;
  logic [15:0] hi_q;
  logic [1:0]  nf_q;
  logic        fall;
  logic        okd;
  logic        dim1;
  assign fall = zc_q & ~zero_cross_i & ctl_q[0];
  assign okd  = (hwdata_i != 32'h0) && (hwdata_i <= (ctl_q[1] ? 32'h9C : 32'hBC));
  assign dim1 = (mode_q[1:0] == 2'h1);
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      {pend_q, adr_q, ctl_q, mode_q, d1_q, d12_q} <= '0;
    end else begin
      // Register update lands at the wait-state edge, as in the design
      if (pend_q && !hreadyout_o) begin
        pend_q <= 1'b0;
        if (adr_q == 8'h00) ctl_q <= hwdata_i[1:0];
        if (adr_q == 8'h04) mode_q <= hwdata_i[23:0];
        if (adr_q == 8'h40 && okd) d1_q <= hwdata_i[7:0];
        if (adr_q == 8'h6C && okd) d12_q <= hwdata_i[7:0];
      end
      if (hsel_i && hready_i && htrans_i[1]) begin
        pend_q <= hwrite_i;
        adr_q  <= haddr_i[7:0];
      end
    end
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      {zc_q, seen_q, sc_q, s1_q, s12_q, nf_q, hi_q} <= '0;
    end else begin
      zc_q <= zero_cross_i;
      hi_q <= dimmer_out_o[5] ? hi_q + 16'h1 : 16'h0;
      if (fall) begin
        seen_q <= 1'b1;
        sc_q   <= 32'h0;
        s1_q   <= d1_q;
        s12_q  <= d12_q;
        nf_q   <= 2'h0;
      end else begin
        if (sc_q != 32'hFFFF_FFFF) sc_q <= sc_q + 32'h1;
        // Rising edge: high now, and the run counter says low last cycle
        if (dimmer_out_o[5] && hi_q == 16'h0) nf_q <= nf_q + 2'h1;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_fire_time;
    $rose(dimmer_out_o[5]) && dim1 |-> sc_q >= s1_q * TICK_CYC && sc_q <= s1_q * TICK_CYC + 6;
  endproperty
  a_fire_time: assert property (p_fire_time) else $error("ch1 fired off its slot");
  property p_ch12_map;
    $rose(dimmer_out_o[16]) && mode_q[23:22] == 2'h1 |-> sc_q >= s12_q * TICK_CYC && sc_q <= s12_q * TICK_CYC + 6;
  endproperty
  a_ch12_map: assert property (p_ch12_map) else $error("ch12 fired off its slot");
  property p_pulse_hold;
    $rose(dimmer_out_o[5]) |=> dimmer_out_o[5][*8];
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("firing pulse too short");
  property p_pulse_end;
    dim1 |-> hi_q <= PULSE_CYC + 2;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("firing pulse held too long");
  property p_once;
    $rose(dimmer_out_o[5]) && dim1 |-> nf_q == 2'h0;
  endproperty
  a_once: assert property (p_once) else $error("ch1 fired twice in a half cycle");
  property p_gate;
    $rose(dimmer_out_o[5]) && dim1 |-> seen_q;
  endproperty
  a_gate: assert property (p_gate) else $error("ch1 fired with no enabled crossing");
  property p_on;
    (mode_q[1:0] == 2'h2) [*4] |-> dimmer_out_o[5];
  endproperty
  a_on: assert property (p_on) else $error("ch1 not held high in on mode");
  property p_off;
    (mode_q[1] == mode_q[0]) [*4] |-> !dimmer_out_o[5];
  endproperty
  a_off: assert property (p_off) else $error("ch1 high in off mode");
endmodule // padm_dimmer_assertions

bind padm_dimmer padm_dimmer_assertions #(.TICK_CYC(TICK_CYC)) u_chk (
  .clk_i        (clk_i),
  .reset_i      (reset_i),
  .hsel_i       (hsel_i),
  .haddr_i      (haddr_i),
  .htrans_i     (htrans_i),
  .hwrite_i     (hwrite_i),
  .hwdata_i     (hwdata_i),
  .hready_i     (hready_i),
  .hreadyout_o  (hreadyout_o),
  .zero_cross_i (zero_cross_i),
  .dimmer_out_o (dimmer_out_o)
);

// File: padm_mains_model.sv
// Zero-cross detector model: one falling edge at each half-cycle start.
// Assumes the bench raises run_i when mains should be present.
`timescale 1ns/10ps
module padm_mains_model #(
  parameter int HALF_CYC = 3000
) (
  // Clock and control
  input  wire logic clk_i,
  input  wire logic run_i,
  // Detector output
  output logic      zero_cross_o
);
  int cnt_q;
  always_ff @(posedge clk_i) begin
    cnt_q <= (!run_i || cnt_q == HALF_CYC - 1) ? 0 : cnt_q + 1;
  end
  // Line carries crossings only, nothing else shares it
  assign zero_cross_o = !(run_i && cnt_q < 100);
endmodule // padm_mains_model

// File: tb_phase_angle_dimmer.sv
// Bench for the dimmer: AHB-Lite register tasks and a mains model.
// Assumes one clock and hready looped back from hreadyout.
`timescale 1ns/10ps
module tb_phase_angle_dimmer;
  localparam int TICK = 40;
  localparam int HALF = 3000;
  logic        clk_i    = 1'b0;
  logic        reset_i  = 1'b1;
  logic        hwrite_i = 1'b0;
  logic        run      = 1'b0;
  logic [31:0] haddr_i  = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic [31:0] hrdata_o;
  logic [31:0] rd;
  logic        hreadyout_o;
  logic        hresp;
  logic        zc;
  logic [16:5] dout;
  logic [16:5] dout_q   = '0;
  int          rises[16:5];
  int          n_errors    = 0;
  int          check_count = 0;
  always #2 clk_i = ~clk_i;
  padm_dimmer #(.TICK_CYC(TICK)) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .hsel_i(1'b1), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hsize_i(3'h2), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp), .zero_cross_i(zc), .dimmer_out_o(dout)
  );
  padm_mains_model #(.HALF_CYC(HALF)) u_mains (.clk_i(clk_i), .run_i(run), .zero_cross_o(zc));
  always @(posedge clk_i) begin
    dout_q <= dout;
    for (int b = 5; b <= 16; b++) if (dout[b] && !dout_q[b]) rises[b]++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    foreach (rises[b]) rises[b] = 0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rdc(8'h00, 32'h0, "ctrl");
    rdc(8'h40, 32'h0, "delay1");
    wr(8'h20, 32'h5A);
    rdc(8'h20, 32'h0, "unmapped");
    $display("test reset done");
    wr(8'h40, 32'hBC);
    rdc(8'h40, 32'hBC, "delay1 max50");
    wr(8'h40, 32'hBD);
    rdc(8'h40, 32'hBC, "delay1 over50");
    rdc(8'h0C, 32'h1, "err");
    wr(8'h0C, 32'h1);
    rdc(8'h0C, 32'h0, "err clear");
    wr(8'h00, 32'h2);
    wr(8'h40, 32'h9D);
    rdc(8'h40, 32'hBC, "delay1 over60");
    wr(8'h40, 32'h9C);
    rdc(8'h40, 32'h9C, "delay1 max60");
    wr(8'h40, 32'h0);
    rdc(8'h40, 32'h9C, "delay1 zero");
    $display("test range done");
    // Crossings arrive before the enable and must be ignored
    wr(8'h00, 32'h0);
    wr(8'h40, 32'h1);
    wr(8'h6C, 32'h3);
    wr(8'h04, 32'h40_0001);
    run <= 1'b1;
    repeat (HALF) @(posedge clk_i);
    rdc(8'h10, 32'h0, "fired gated");
    chk("ch1 gated", 32'h0, rises[5]);
    run <= 1'b0;
    wr(8'h00, 32'h1);
    run <= 1'b1;
    repeat (HALF + HALF / 2) @(posedge clk_i);
    wr(8'h40, 32'h5);
    repeat (2 * HALF) @(posedge clk_i);
    run <= 1'b0;
    chk("ch1 pulses", 32'h4, rises[5]);
    chk("ch12 pulses", 32'h4, rises[16]);
    for (int b = 6; b <= 15; b++) chk("idle ch", 32'h0, rises[b]);
    rdc(8'h10, 32'h801, "fired");
    rdc(8'h40, 32'h5, "delay1 kept");
    bus(1'b0, 8'h08, 32'h0);
    chk("half count", 32'h4, rd & 32'h0000_FFFF);
    $display("test dimming done");
    wr(8'h04, 32'h2);
    repeat (HALF) @(posedge clk_i);
    chk("ch1 on", 32'h1, dout[5]);
    wr(8'h04, 32'h0);
    repeat (8) @(posedge clk_i);
    chk("ch1 off", 32'h0, dout[5]);
    wr(8'h04, 32'h2);
    wr(8'h04, 32'h3);
    repeat (8) @(posedge clk_i);
    chk("ch1 off3", 32'h0, dout[5]);
    $display("test levels done");
    // Reset in mid-run must clear control and mode again
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rdc(8'h00, 32'h0, "ctrl after reset");
    rdc(8'h04, 32'h0, "mode after reset");
    chk("ch1 after reset", 32'h0, dout[5]);
    $display("test reset again done");
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    end_of_test();
  end
endmodule // tb_phase_angle_dimmer
